// [rtl/mpf_pkg.sv]
// Shared constants for the pause flow control unit and its host agent
package mpf_pkg;
  // Register map, word index on the register port
  localparam logic [3:0]  FLOW_IDX      = 4'h8;
  localparam logic [31:0] FLOW_RESET    = 32'h0000_0000;
  // Field positions inside the flow control register
  localparam int          BUSY_BIT      = 0;
  localparam int          ENABLE_BIT    = 1;
  localparam int          PASS_BIT      = 2;
  localparam int          PT_LSB        = 16;
  localparam int          PT_MSB        = 31;
  // Pause control frame layout, byte offsets without FCS
  localparam logic [47:0] PAUSE_DA      = 48'h0180_C200_0001;
  localparam logic [15:0] CTRL_TYPE     = 16'h8808;
  localparam logic [15:0] PAUSE_OPCODE  = 16'h0001;
  localparam logic [5:0]  OFS_SA        = 6'h06;
  localparam logic [5:0]  OFS_TYPE      = 6'h0C;
  localparam logic [5:0]  OFS_OPC       = 6'h0E;
  localparam logic [5:0]  OFS_PT        = 6'h10;
  localparam logic [5:0]  OFS_PT_LO     = 6'h11;
  localparam logic [5:0]  OFS_HDR_END   = 6'h12;
  localparam logic [5:0]  FRAME_LEN     = 6'h3C;
  localparam logic [5:0]  IDX_MAX       = 6'h3F;
  // Slot time is 512 bit times at 100 Mb/s
  localparam int          SLOT_TIME_NS  = 5120;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          SLOT_CYCLES   = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// [rtl/mpf_if.sv]
// Register port, flow request and receive delivery between device and host
`timescale 1ns/1ps
interface mpf_if;
  logic        reg_wr;
  logic        reg_rd;
  logic [3:0]  reg_idx;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  logic        afc_pause_req;
  logic        afc_hold;
  logic        rxh_valid;
  logic [7:0]  rxh_data;
  logic        rxh_last;
  logic        rxh_filter_pass;

  modport dev  (input reg_wr, reg_rd, reg_idx, reg_wdata, afc_pause_req, afc_hold,
                output reg_rdata, reg_rvalid, rxh_valid, rxh_data, rxh_last, rxh_filter_pass);
  modport host (output reg_wr, reg_rd, reg_idx, reg_wdata, afc_pause_req, afc_hold,
                input reg_rdata, reg_rvalid, rxh_valid, rxh_data, rxh_last, rxh_filter_pass);
endinterface // mpf_if

// [rtl/mpf_flow_ctrl.sv]
// Pause flow control unit of the MAC: generation, decode, back pressure
`timescale 1ns/1ps
module mpf_flow_ctrl
  import mpf_pkg::*;
#(
  parameter int SLOT_CNT = mpf_pkg::SLOT_CYCLES
)(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Host side
  mpf_if.dev               hif,
  // MAC mode and station address
  input  wire logic        full_duplex,
  input  wire logic        tx_enable,
  input  wire logic        promiscuous,
  input  wire logic [47:0] station_addr,
  // Pause frame stream to transmit path
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             tx_last,
  input  wire logic        tx_ready,
  // Medium control
  output logic             back_pressure,
  output logic             tx_paused,
  // Received frame stream from receive path
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  input  wire logic        rx_crc_ok,
  input  wire logic        rx_addr_pass
);
  import mpf_pkg::*;

  typedef enum logic [1:0] {
    MPF_IDLE = 2'b01,
    MPF_SEND = 2'b10
  } mpf_tx_e;

  mpf_tx_e     tx_state;
  logic [15:0] pause_time_value;
  logic        pause_function_enable;
  logic        forward_pause_frames;
  logic        pause_tx_in_progress;
  logic [5:0]  tx_idx;
  logic [5:0]  rx_idx;
  logic        rx_hdr_match;
  logic [15:0] rx_pt;
  logic [15:0] pause_quanta;
  logic [15:0] slot_cnt;
  logic        rx_is_pause;
  logic        rx_pause_act;

  // Byte of a pause frame at a given offset; used for sending and matching
  function automatic logic [7:0] frame_byte(input logic [5:0] idx, input logic [15:0] pt,
                                            input logic [47:0] sa);
    logic [7:0] b;
    b = 8'h00;
    if (idx < OFS_SA)
      b = PAUSE_DA[8'(47 - 8 * idx) -: 8];
    else if (idx < OFS_TYPE)
      b = sa[8'(47 - 8 * (idx - OFS_SA)) -: 8];
    else if (idx < OFS_OPC)
      b = CTRL_TYPE[8'(15 - 8 * (idx - OFS_TYPE)) -: 8];
    else if (idx < OFS_PT)
      b = PAUSE_OPCODE[8'(15 - 8 * (idx - OFS_OPC)) -: 8];
    else if (idx < OFS_HDR_END)
      b = pt[8'(15 - 8 * (idx - OFS_PT)) -: 8];
    return b;
  endfunction

  // Control fields; the busy position of a write is ignored, hardware owns it
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      pause_time_value      <= FLOW_RESET[PT_MSB:PT_LSB];
      pause_function_enable <= FLOW_RESET[ENABLE_BIT];
      forward_pause_frames  <= FLOW_RESET[PASS_BIT];
    end
    else if (hif.reg_wr && hif.reg_idx == FLOW_IDX)
    begin
      pause_time_value      <= hif.reg_wdata[PT_MSB:PT_LSB];
      pause_function_enable <= hif.reg_wdata[ENABLE_BIT];
      forward_pause_frames  <= hif.reg_wdata[PASS_BIT];
    end
  end

  // Read answer one cycle after the strobe; unmapped words read zero
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      hif.reg_rdata  <= 32'h0000_0000;
      hif.reg_rvalid <= 1'b0;
    end
    else
    begin
      hif.reg_rvalid <= hif.reg_rd;
      hif.reg_rdata  <= 32'h0000_0000;
      if (hif.reg_rd && hif.reg_idx == FLOW_IDX)
      begin
        hif.reg_rdata[PT_MSB:PT_LSB] <= pause_time_value;
        hif.reg_rdata[PASS_BIT]      <= forward_pause_frames;
        hif.reg_rdata[ENABLE_BIT]    <= pause_function_enable;
        hif.reg_rdata[BUSY_BIT]      <= pause_tx_in_progress;
      end
    end
  end

  // Back pressure only in half duplex, enabled, transmitter on
  assign back_pressure = !full_duplex && pause_function_enable && tx_enable
                         && hif.afc_hold;

  // Busy covers the frame in flight or the back pressure period
  assign pause_tx_in_progress = (tx_state == MPF_SEND) || back_pressure;

  // Pause frame sender; a frame once started runs to its end
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      tx_state <= MPF_IDLE;
      tx_idx   <= 6'h00;
      tx_data  <= 8'h00;
      tx_last  <= 1'b0;
    end
    else
    begin
      case (tx_state)
        MPF_IDLE:
        begin
          if (hif.afc_pause_req && full_duplex && tx_enable)
          begin
            tx_state <= MPF_SEND;
            tx_idx   <= 6'h00;
            tx_data  <= frame_byte(6'h00, pause_time_value, station_addr);
            tx_last  <= 1'b0;
          end
        end
        MPF_SEND:
        begin
          if (tx_ready)
          begin
            if (tx_last)
            begin
              tx_state <= MPF_IDLE;
              tx_last  <= 1'b0;
              tx_data  <= 8'h00;
            end
            else
            begin
              tx_idx  <= tx_idx + 6'h01;
              tx_data <= frame_byte(tx_idx + 6'h01, pause_time_value, station_addr);
              tx_last <= (tx_idx + 6'h01) == (FRAME_LEN - 6'h01);
            end
          end
        end
        default:
        begin
          tx_state <= MPF_IDLE;
        end
      endcase
    end
  end

  assign tx_valid = (tx_state == MPF_SEND);

  // Receive header matching; the source address bytes are not compared
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      rx_idx       <= 6'h00;
      rx_hdr_match <= 1'b1;
      rx_pt        <= 16'h0000;
    end
    else if (rx_valid)
    begin
      if (rx_last)
      begin
        rx_idx       <= 6'h00;
        rx_hdr_match <= 1'b1;
      end
      else
      begin
        rx_idx <= (rx_idx == IDX_MAX) ? rx_idx : rx_idx + 6'h01;
        if (rx_idx < OFS_PT && (rx_idx < OFS_SA || rx_idx >= OFS_TYPE)
            && rx_data != frame_byte(rx_idx, 16'h0000, 48'h0000_0000_0000))
          rx_hdr_match <= 1'b0;
        if (rx_idx == OFS_PT)
          rx_pt[15:8] <= rx_data;
        if (rx_idx == OFS_PT_LO)
          rx_pt[7:0] <= rx_data;
      end
    end
  end

  // A frame ending before its pause time bytes is not a pause frame
  assign rx_is_pause  = rx_valid && rx_last && rx_hdr_match && rx_idx > OFS_PT_LO;
  assign rx_pause_act = rx_is_pause && rx_crc_ok && full_duplex
                        && pause_function_enable;

  // Pause timer in slot quanta; a fresh pause frame reloads it
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      pause_quanta <= 16'h0000;
      slot_cnt     <= 16'h0000;
    end
    else if (rx_pause_act)
    begin
      pause_quanta <= rx_pt;
      slot_cnt     <= 16'(SLOT_CNT - 1);
    end
    else if (!pause_function_enable || !full_duplex)
    begin
      pause_quanta <= 16'h0000;
      slot_cnt     <= 16'h0000;
    end
    else if (pause_quanta != 16'h0000)
    begin
      if (slot_cnt == 16'h0000)
      begin
        pause_quanta <= pause_quanta - 16'h0001;
        slot_cnt     <= 16'(SLOT_CNT - 1);
      end
      else
        slot_cnt <= slot_cnt - 16'h0001;
    end
  end

  assign tx_paused = (pause_quanta != 16'h0000);

  // Every frame's data goes up, one cycle late; status rides on the last byte
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      hif.rxh_valid       <= 1'b0;
      hif.rxh_data        <= 8'h00;
      hif.rxh_last        <= 1'b0;
      hif.rxh_filter_pass <= 1'b0;
    end
    else
    begin
      hif.rxh_valid <= rx_valid;
      hif.rxh_data  <= rx_data;
      hif.rxh_last  <= rx_valid && rx_last;
      if (rx_valid && rx_last)
      begin
        if (promiscuous)
          hif.rxh_filter_pass <= 1'b1;
        else if (rx_is_pause)
          hif.rxh_filter_pass <= forward_pause_frames && rx_addr_pass;
        else
          hif.rxh_filter_pass <= rx_addr_pass;
      end
      else
        hif.rxh_filter_pass <= 1'b0;
    end
  end
endmodule // mpf_flow_ctrl

// [rtl/mpf_host_agent.sv]
// Host agent: programs the flow register safely and sorts received frames
`timescale 1ns/1ps
module mpf_host_agent
  import mpf_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Device side
  mpf_if.host              hif,
  // Configuration command
  input  wire logic        cfg_valid,
  input  wire logic [15:0] cfg_pause_time,
  input  wire logic        cfg_enable,
  input  wire logic        cfg_pass,
  output logic             cfg_ready,
  // Software flow requests through the automatic flow config
  input  wire logic        sw_pause_req,
  input  wire logic        sw_hold,
  // Received frames with the keep decision
  output logic             usr_rx_valid,
  output logic [7:0]       usr_rx_data,
  output logic             usr_rx_last,
  output logic             usr_rx_keep
);
  import mpf_pkg::*;

  typedef enum logic [3:0] {
    MPH_IDLE  = 4'b0001,
    MPH_POLL  = 4'b0010,
    MPH_WAIT  = 4'b0100,
    MPH_WRITE = 4'b1000
  } mph_state_e;

  mph_state_e  state;
  logic        second_pass;
  logic [15:0] pt_hold;
  logic        en_hold;
  logic        pass_hold;
  logic [31:0] old_word;

  // Poll busy, write pause time with old controls, poll again, write all
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state         <= MPH_IDLE;
      second_pass   <= 1'b0;
      pt_hold       <= 16'h0000;
      en_hold       <= 1'b0;
      pass_hold     <= 1'b0;
      old_word      <= FLOW_RESET;
      hif.reg_wr    <= 1'b0;
      hif.reg_rd    <= 1'b0;
      hif.reg_idx   <= FLOW_IDX;
      hif.reg_wdata <= 32'h0000_0000;
    end
    else
    begin
      hif.reg_wr <= 1'b0;
      hif.reg_rd <= 1'b0;
      case (state)
        MPH_IDLE:
        begin
          if (cfg_valid)
          begin
            pt_hold     <= cfg_pause_time;
            en_hold     <= cfg_enable;
            pass_hold   <= cfg_pass;
            second_pass <= 1'b0;
            state       <= MPH_POLL;
          end
        end
        MPH_POLL:
        begin
          hif.reg_rd  <= 1'b1;
          hif.reg_idx <= FLOW_IDX;
          state       <= MPH_WAIT;
        end
        MPH_WAIT:
        begin
          if (hif.reg_rvalid)
          begin
            old_word <= hif.reg_rdata;
            // Busy must read clear before any write
            state    <= hif.reg_rdata[BUSY_BIT] ? MPH_POLL : MPH_WRITE;
          end
        end
        MPH_WRITE:
        begin
          hif.reg_wr    <= 1'b1;
          hif.reg_idx   <= FLOW_IDX;
          hif.reg_wdata <= 32'h0000_0000;
          hif.reg_wdata[PT_MSB:PT_LSB] <= pt_hold;
          hif.reg_wdata[ENABLE_BIT] <= second_pass ? en_hold : old_word[ENABLE_BIT];
          hif.reg_wdata[PASS_BIT]   <= second_pass ? pass_hold : old_word[PASS_BIT];
          second_pass   <= 1'b1;
          state         <= second_pass ? MPH_IDLE : MPH_POLL;
        end
        default:
        begin
          state <= MPH_IDLE;
        end
      endcase
    end
  end

  assign cfg_ready = (state == MPH_IDLE);

  // Software flow requests go to the device as its automatic flow config
  assign hif.afc_pause_req = sw_pause_req;
  assign hif.afc_hold      = sw_hold;

  // Frame data passes on; the keep flag marks the last byte
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      usr_rx_valid <= 1'b0;
      usr_rx_data  <= 8'h00;
      usr_rx_last  <= 1'b0;
      usr_rx_keep  <= 1'b0;
    end
    else
    begin
      usr_rx_valid <= hif.rxh_valid;
      usr_rx_data  <= hif.rxh_data;
      usr_rx_last  <= hif.rxh_last;
      usr_rx_keep  <= hif.rxh_last && hif.rxh_filter_pass;
    end
  end
endmodule // mpf_host_agent

// [bench/mpf_flow_chk.sv]
// Checker for the register port and receive delivery between both ends
`timescale 1ns/1ps
module mpf_flow_chk
  import mpf_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rstn,
  // Register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [3:0]  reg_idx,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rvalid,
  // Receive delivery
  input wire logic        rxh_last,
  input wire logic        rxh_filter_pass
);
  logic        last_busy;
  logic [15:0] sh_pt;
  logic [1:0]  sh_ctl;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Busy as the host last read it
  always_ff @(posedge sys_clk)
    if (!rstn)
      last_busy <= 1'b0;
    else if (reg_rvalid)
      last_busy <= reg_rdata[BUSY_BIT];

  // Shadow of written fields; busy is hardware owned
  always_ff @(posedge sys_clk)
    if (!rstn)
    begin
      sh_pt  <= 16'h0000;
      sh_ctl <= 2'h0;
    end
    else if (reg_wr && reg_idx == FLOW_IDX)
    begin
      sh_pt  <= reg_wdata[PT_MSB:PT_LSB];
      sh_ctl <= reg_wdata[PASS_BIT:ENABLE_BIT];
    end

  property p_rd_ans;
    reg_rd |=> reg_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered next cycle");

  property p_rv_cause;
    reg_rvalid |-> $past(reg_rd);
  endproperty
  a_rv_cause: assert property (p_rv_cause)
    else $error("read data without a read");

  property p_readback;
    reg_rvalid && $past(reg_idx) == FLOW_IDX |-> reg_rdata[31:1] == {sh_pt, 13'h0000, sh_ctl};
  endproperty
  a_readback: assert property (p_readback)
    else $error("flow word differs from last write");

  property p_busy_zero;
    reg_wr |-> !reg_wdata[BUSY_BIT];
  endproperty
  a_busy_zero: assert property (p_busy_zero)
    else $error("write with busy bit set");

  property p_wr_idle;
    reg_wr |-> !last_busy;
  endproperty
  a_wr_idle: assert property (p_wr_idle)
    else $error("write while busy last read high");

  property p_pt_first;
    reg_wr && reg_wdata[ENABLE_BIT] && !sh_ctl[0] |-> reg_wdata[PT_MSB:PT_LSB] == sh_pt;
  endproperty
  a_pt_first: assert property (p_pt_first)
    else $error("enable set before pause time written");

  property p_flag_last;
    rxh_filter_pass |-> rxh_last;
  endproperty
  a_flag_last: assert property (p_flag_last)
    else $error("filter flag outside last byte");

  property p_rd_flow;
    reg_rd |-> reg_idx == FLOW_IDX;
  endproperty
  a_rd_flow: assert property (p_rd_flow)
    else $error("host polled a foreign index");
endmodule // mpf_flow_chk

// [bench/mac_pause_flow_control_tb.sv]
// Bench joining the pause flow unit and its host agent face to face
`timescale 1ns/1ps
module mac_pause_flow_control_tb;
  import mpf_pkg::*;
  localparam int SLOT = 4;
  logic        sys_clk = 1'b0;
  logic        rstn, cfg_valid, cfg_enable, cfg_pass, cfg_ready;
  logic        sw_pause_req, sw_hold, usr_rx_valid, usr_rx_last, usr_rx_keep;
  logic        full_duplex, tx_enable, promiscuous, tx_valid, tx_last, tx_ready;
  logic        back_pressure, tx_paused, rx_valid, rx_last, rx_crc_ok, rx_addr_pass;
  logic [15:0] cfg_pause_time, cur_pt;
  logic [7:0]  usr_rx_data, tx_data, rx_data;
  logic [47:0] station_addr;
  logic [7:0]  txq[$], rxq[$];
  logic        kq[$];
  int          error_cnt = 0, tests_run = 0, seed = 32'h9446_2133;

  mpf_if hif ();
  mpf_flow_ctrl #(.SLOT_CNT(SLOT)) u_mpf_flow_ctrl (.sys_clk(sys_clk), .rstn(rstn), .hif(hif),
    .full_duplex(full_duplex), .tx_enable(tx_enable), .promiscuous(promiscuous),
    .station_addr(station_addr), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .back_pressure(back_pressure), .tx_paused(tx_paused),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_crc_ok(rx_crc_ok),
    .rx_addr_pass(rx_addr_pass));
  mpf_host_agent u_mpf_host_agent (.sys_clk(sys_clk), .rstn(rstn), .hif(hif),
    .cfg_valid(cfg_valid), .cfg_pause_time(cfg_pause_time), .cfg_enable(cfg_enable),
    .cfg_pass(cfg_pass), .cfg_ready(cfg_ready), .sw_pause_req(sw_pause_req), .sw_hold(sw_hold),
    .usr_rx_valid(usr_rx_valid), .usr_rx_data(usr_rx_data), .usr_rx_last(usr_rx_last),
    .usr_rx_keep(usr_rx_keep));
  mpf_flow_chk u_mpf_flow_chk (.sys_clk(sys_clk), .rstn(rstn), .reg_wr(hif.reg_wr),
    .reg_rd(hif.reg_rd), .reg_idx(hif.reg_idx), .reg_wdata(hif.reg_wdata),
    .reg_rdata(hif.reg_rdata), .reg_rvalid(hif.reg_rvalid), .rxh_last(hif.rxh_last),
    .rxh_filter_pass(hif.rxh_filter_pass));

  // Free running clock
  always #5 sys_clk = ~sys_clk;

  // Random stalls from the transmit path
  always @(negedge sys_clk)
    tx_ready <= 1'($random(seed));

  task automatic summarize();
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int k);
    if (k >= 400)
    begin
      error_cnt++;
      summarize();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Byte i of a pause frame, header then zero pad
  function automatic logic [7:0] fb(input int i, input logic [15:0] pt, input logic [47:0] sa);
    logic [143:0] h;
    h = {PAUSE_DA, sa, CTRL_TYPE, PAUSE_OPCODE, pt};
    return i < 18 ? h[143 - 8 * i -: 8] : 8'h00;
  endfunction

  // Config held until taken, then wait for the agent to go idle
  task automatic cfg(input logic [15:0] pt, input logic en, input logic ps);
    int k;
    cfg_pause_time = pt;
    cfg_enable = en;
    cfg_pass = ps;
    cur_pt = pt;
    cfg_valid = 1'b1;
    for (k = 0; k < 400 && !cfg_ready; k++)
      cyc(1);
    tmo(k);
    cyc(1);
    cfg_valid = 1'b0;
    for (k = 0; k < 400 && !cfg_ready; k++)
      cyc(1);
    tmo(k);
  endtask

  task automatic send_pause();
    for (int i = 0; i < 60; i++)
      txq.push_back(fb(i, cur_pt, station_addr));
    sw_pause_req = 1'b1;
    cyc(1);
    sw_pause_req = 1'b0;
  endtask

  task automatic rx_frame(input logic [15:0] pt, input logic kp);
    for (int i = 0; i < 60; i++)
    begin
      rx_valid = 1'b1;
      rx_data = fb(i, pt, ~station_addr);
      rx_last = i == 59;
      rxq.push_back(rx_data);
      cyc(1);
    end
    rx_valid = 1'b0;
    rx_last = 1'b0;
    kq.push_back(kp);
    // Idle byte time, so a following frame never re-drives valid in one step
    cyc(1);
  endtask

  task automatic pz(input int n, input logic exp);
    cyc(n);
    check(tx_paused, exp);
  endtask

  // Scoreboard: oldest note against each result seen
  always @(posedge sys_clk)
    if (rstn)
    begin
      if (tx_valid && tx_ready)
      begin
        check(tx_data, txq.size() != 0 ? txq.pop_front() : 8'hxx);
        check(tx_last, txq.size() == 0);
      end
      if (usr_rx_valid)
        check(usr_rx_data, rxq.size() != 0 ? rxq.pop_front() : 8'hxx);
      if (usr_rx_valid && usr_rx_last)
        check(usr_rx_keep, kq.size() != 0 ? kq.pop_front() : 1'bx);
    end

  initial
  begin
    int k;
    rstn = 1'b0;
    cfg_valid = 1'b0;
    sw_pause_req = 1'b0;
    sw_hold = 1'b0;
    full_duplex = 1'b1;
    tx_enable = 1'b1;
    promiscuous = 1'b0;
    station_addr = 48'({$random(seed), $random(seed)});
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_crc_ok = 1'b1;
    rx_addr_pass = 1'b1;
    cyc(4);
    rstn = 1'b1;
    // Frame out, then reprogram while busy
    cfg(16'($random(seed)), 1'b1, 1'b0);
    send_pause();
    cfg(16'h0003, 1'b1, 1'b0);
    check(txq.size(), 0);
    send_pause();
    for (k = 0; k < 400 && txq.size() != 0; k++)
      cyc(1);
    tmo(k);
    // Pause received and timed, then restarted
    rx_frame(16'h0003, 1'b0);
    pz(2, 1'b1);
    pz(8, 1'b1);
    pz(6, 1'b0);
    rx_frame(16'h0014, 1'b0);
    rx_frame(16'h0014, 1'b0);
    pz(70, 1'b1);
    pz(15, 1'b0);
    // Frames that must not pause
    rx_addr_pass = 1'b0;
    rx_crc_ok = 1'b0;
    rx_frame(16'h0014, 1'b0);
    pz(2, 1'b0);
    rx_crc_ok = 1'b1;
    full_duplex = 1'b0;
    rx_frame(16'h0014, 1'b0);
    pz(2, 1'b0);
    full_duplex = 1'b1;
    cfg(16'h0003, 1'b0, 1'b1);
    rx_frame(16'h0014, 1'b0);
    pz(2, 1'b0);
    // Filter flag choices
    cfg(16'h0003, 1'b1, 1'b1);
    rx_addr_pass = 1'b1;
    rx_frame(16'h0001, 1'b1);
    cfg(16'h0003, 1'b1, 1'b0);
    rx_addr_pass = 1'b0;
    promiscuous = 1'b1;
    rx_frame(16'h0001, 1'b1);
    promiscuous = 1'b0;
    // Half duplex pressure and disabled transmitter
    full_duplex = 1'b0;
    sw_hold = 1'b1;
    cyc(2);
    check(back_pressure, 1'b1);
    // Busy held by back pressure keeps the agent polling, no write lands
    cfg_valid = 1'b1;
    cyc(1);
    cfg_valid = 1'b0;
    cyc(30);
    check(cfg_ready, 1'b0);
    tx_enable = 1'b0;
    cyc(2);
    check(back_pressure, 1'b0);
    cyc(30);
    check(cfg_ready, 1'b1);
    sw_hold = 1'b0;
    full_duplex = 1'b1;
    sw_pause_req = 1'b1;
    cyc(1);
    sw_pause_req = 1'b0;
    cyc(80);
    check(tx_valid, 1'b0);
    summarize();
  end
endmodule // mac_pause_flow_control_tb
